// ===== hdl/jlp_pkg.sv
// Constants, types and mode tables for the lane sample packer.
// Assumes one 250 MHz clock and a synchronous active-high reset.
package jlp_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int CHANS = 4;
    localparam int LANES = 8;
    localparam int SW = 9;
    localparam int GATHER = 8;
    localparam int LANE_W = 40;
    localparam int FRAME_W = LANES * LANE_W;
    localparam int BUF_W = FRAME_W + LANES + 3;
    localparam int BUF_DEPTH = 2;
    localparam int SLOT_W = 12;
    localparam int STRM_W = 96;
    localparam int HALF_W = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] RST_CNT = 3'h0;
    localparam logic [3:0] RST_MODE = 4'h3;
    localparam logic [1:0] RST_VARIANT = 2'h0;

    typedef enum logic [3:0] {
        JLP_M3 = 4'h3,
        JLP_M4 = 4'h4,
        JLP_M5 = 4'h5,
        JLP_M6 = 4'h6,
        JLP_M7 = 4'h7,
        JLP_M8 = 4'h8,
        JLP_M9 = 4'h9,
        JLP_M10 = 4'ha
    } jlp_mode_t;

    typedef enum logic [1:0] {
        JLP_QUAD = 2'h0,
        JLP_DUAL = 2'h1,
        JLP_SINGLE = 2'h2
    } jlp_variant_t;

    // ----------------------------------------------------------------
    // Mode tables
    // ----------------------------------------------------------------
    // Samples per channel per frame; zero marks an unsupported mode
    function automatic logic [3:0] jlp_spf(input logic [3:0] m);
        case (m)
            JLP_M3: jlp_spf = 4'h4;
            JLP_M4, JLP_M5, JLP_M7: jlp_spf = 4'h1;
            JLP_M6, JLP_M8, JLP_M9: jlp_spf = 4'h2;
            JLP_M10: jlp_spf = 4'h8;
            default: jlp_spf = 4'h0;
        endcase
    endfunction

    function automatic logic [2:0] jlp_octets(input logic [3:0] m);
        case (m)
            JLP_M3, JLP_M10: jlp_octets = 3'h5;
            JLP_M4, JLP_M5, JLP_M6: jlp_octets = 3'h2;
            JLP_M8: jlp_octets = 3'h3;
            JLP_M7, JLP_M9: jlp_octets = 3'h1;
            default: jlp_octets = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] jlp_chans(input logic [1:0] v);
        case (v)
            JLP_QUAD: jlp_chans = 3'h4;
            JLP_DUAL: jlp_chans = 3'h2;
            default: jlp_chans = 3'h1;
        endcase
    endfunction

    // Lanes in use, indexed quad / dual / single
    function automatic logic [3:0] jlp_lanes(input logic [3:0] m, input logic [1:0] v);
        logic [11:0] t;
        t = 12'h000;
        case (m)
            JLP_M3, JLP_M7, JLP_M8: t = 12'h421;
            JLP_M4: t = 12'h321;
            JLP_M5: t = 12'h211;
            JLP_M6: t = 12'h632;
            JLP_M9, JLP_M10: t = 12'h842;
            default: t = 12'h000;
        endcase
        case (v)
            JLP_QUAD: jlp_lanes = t[11:8];
            JLP_DUAL: jlp_lanes = t[7:4];
            default: jlp_lanes = t[3:0];
        endcase
    endfunction

endpackage

// ===== hdl/jlp_buf_if.sv
// Carrier between the packer and its two-entry frame buffer.
// Assumes both ends share the packer's clock.
`timescale 1ns/10ps
interface jlp_buf_if;
    import jlp_pkg::*;
    logic push_valid;
    logic push_ready;
    logic [BUF_W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [BUF_W-1:0] pop_data;
    modport store (input push_valid, input push_data, input pop_ready,
                   output push_ready, output pop_valid, output pop_data);
    modport user (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data);
endinterface

// ===== hdl/jlp_frame_buf.sv
// Two-entry frame buffer with valid/ready on both sides.
// Assumes push and pop in the same clock domain; read data come from flops.
`timescale 1ns/10ps
module jlp_frame_buf (
    input wire logic clock,
    input wire logic rst,
    jlp_buf_if.store bus
);
    import jlp_pkg::*;

    logic [BUF_W-1:0] mem_r [BUF_DEPTH];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic do_push;
    logic do_pop;

    assign bus.push_ready = (cnt_r != 2'(BUF_DEPTH));
    assign bus.pop_valid = (cnt_r != 2'h0);
    assign bus.pop_data = mem_r[rp_r];
    assign do_push = bus.push_valid && bus.push_ready;
    assign do_pop = bus.pop_valid && bus.pop_ready;

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem_r[wp_r] <= bus.push_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (do_push) begin
                wp_r <= ~wp_r;
            end
            if (do_pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

endmodule

// ===== hdl/jlp_packer.sv
// Transport packer: gathers per-channel samples and maps them onto lane frames.
// Assumes samples arrive one per channel per accepted cycle, synchronous to clock;
// the link layer behind the outputs does coding, scrambling and framing.
`timescale 1ns/10ps

// Overview of operation
// - Mode 3: four 9-bit samples, 5 octets
// - Mode 4: 12-bit slots streamed over lanes
// - Mode 5: lane0 A plus B-or-zero; lane1 C,D
// - Mode 6: two 12-bit slots per channel, streamed
// - Mode 7: one octet per channel lane
// - Mode 8: two 12-bit slots per lane
// - Mode 9: even/odd samples on paired lanes
// - Mode 10: paired lanes, 10-bit slots, even/odd split
// - Lane use limited by part variant
module jlp_packer (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] link_mode_select,
    input wire logic [1:0] part_variant,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [jlp_pkg::CHANS*jlp_pkg::SW-1:0] in_samp,
    output logic out_valid,
    input wire logic out_ready,
    output logic [jlp_pkg::FRAME_W-1:0] out_lanes,
    output logic [jlp_pkg::LANES-1:0] out_lane_en,
    output logic [2:0] out_octets
);
    import jlp_pkg::*;

    // ----------------------------------------------------------------
    // Gathering
    // ----------------------------------------------------------------
    logic [3:0] mode_r;
    logic [1:0] variant_r;
    logic [2:0] cnt_r;
    logic pend_r;
    logic [SW-1:0] samp_r [CHANS][GATHER];
    logic [3:0] spf;
    logic idle;
    logic take;
    logic last;
    logic mode_ok;
    logic mode_held;
    logic frame_done;

    jlp_buf_if bi ();

    assign spf = jlp_spf(mode_r);
    assign idle = (cnt_r == RST_CNT) && !pend_r;
    assign last = ({1'b0, cnt_r} == spf - 4'h1);
    // Unsupported modes stall the input rather than drop samples
    assign mode_ok = (spf != 4'h0);
    assign mode_held = (link_mode_select == mode_r) && (part_variant == variant_r);
    // A mode or variant change is only honoured between frames, so a
    // frame is never built from samples packed under two layouts.
    assign in_ready = !pend_r && mode_ok && (!idle || mode_held);
    assign take = in_valid && in_ready;
    assign frame_done = take && last;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r <= RST_MODE;
            variant_r <= RST_VARIANT;
        end else if (idle) begin
            mode_r <= link_mode_select;
            variant_r <= part_variant;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= RST_CNT;
        end else if (take) begin
            cnt_r <= last ? RST_CNT : cnt_r + 3'h1;
        end
    end

    // Sample stores need no reset: nothing reads them before a frame completes
    always_ff @(posedge clock) begin
        if (take) begin
            for (int c = 0; c < CHANS; c++) begin
                samp_r[c][cnt_r] <= in_samp[c*SW +: SW];
            end
        end
    end

    // Completed frame waits here until the buffer takes it; the input is
    // stalled meanwhile so a receiver stall never overwrites samples.
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (frame_done) begin
            pend_r <= 1'b1;
        end else if (bi.push_ready) begin
            pend_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Frame mapping
    // ----------------------------------------------------------------
    logic [SW-1:0] sm [CHANS][GATHER];
    logic [LANE_W-1:0] lane_v [LANES];
    logic [STRM_W-1:0] strm;
    logic [8:0] en_mask;
    logic [FRAME_W-1:0] lanes_flat;
    logic [7:0] m5_second;

    // Absent channels read as zero, which also yields the zero-fill octets
    always_comb begin
        for (int c = 0; c < CHANS; c++) begin
            for (int k = 0; k < GATHER; k++) begin
                sm[c][k] = (c < int'(jlp_chans(variant_r))) ? samp_r[c][k] : 9'h000;
            end
        end
    end

    // Dual parts send the second channel beside the first; quad and single parts zero-fill
    assign m5_second = (variant_r == JLP_DUAL) ? sm[1][0][8:1] : 8'h00;

    // Octet 0 sits in bits [39:32] of each lane, so octets leave in ascending
    // order and every sample goes MSB first from the lowest-numbered octet it occupies.
    always_comb begin
        strm = '0;
        for (int l = 0; l < LANES; l++) begin
            lane_v[l] = '0;
        end
        case (mode_r)
            JLP_M3: begin
                for (int c = 0; c < CHANS; c++) begin
                    lane_v[c] = {sm[c][0], 1'b0, sm[c][1], 1'b0, sm[c][2], 1'b0, sm[c][3], 1'b0};
                end
            end
            JLP_M4: begin
                // Four 12-bit slots fill three 16-bit lanes; B and C straddle
                for (int c = 0; c < CHANS; c++) begin
                    strm[STRM_W-1-SLOT_W*c -: SLOT_W] = {sm[c][0], 3'h0};
                end
                for (int l = 0; l < 6; l++) begin
                    lane_v[l] = {strm[STRM_W-1-HALF_W*l -: HALF_W], 24'h000000};
                end
            end
            JLP_M5: begin
                lane_v[0] = {sm[0][0][8:1], m5_second, 24'h000000};
                lane_v[1] = {sm[2][0][8:1], sm[3][0][8:1], 24'h000000};
            end
            JLP_M6: begin
                // Slots run A0 A1 B0 B1 ...; a slot may straddle two lanes
                for (int c = 0; c < CHANS; c++) begin
                    for (int k = 0; k < 2; k++) begin
                        strm[STRM_W-1-SLOT_W*(2*c+k) -: SLOT_W] = {sm[c][k], 3'h0};
                    end
                end
                for (int l = 0; l < 6; l++) begin
                    lane_v[l] = {strm[STRM_W-1-HALF_W*l -: HALF_W], 24'h000000};
                end
            end
            JLP_M7: begin
                for (int c = 0; c < CHANS; c++) begin
                    lane_v[c] = {sm[c][0][8:1], 32'h00000000};
                end
            end
            JLP_M8: begin
                for (int c = 0; c < CHANS; c++) begin
                    lane_v[c] = {sm[c][0], 3'h0, sm[c][1], 3'h0, 16'h0000};
                end
            end
            JLP_M9: begin
                // Even sample on the lower lane of the pair
                for (int c = 0; c < CHANS; c++) begin
                    for (int k = 0; k < 2; k++) begin
                        lane_v[2*c+k] = {sm[c][k][8:1], 32'h00000000};
                    end
                end
            end
            JLP_M10: begin
                // Lower lane takes the even samples, upper lane the odd ones
                for (int c = 0; c < CHANS; c++) begin
                    for (int k = 0; k < 2; k++) begin
                        lane_v[2*c+k] = {sm[c][k], 1'b0, sm[c][k+2], 1'b0,
                                         sm[c][k+4], 1'b0, sm[c][k+6], 1'b0};
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            lanes_flat[l*LANE_W +: LANE_W] = lane_v[l];
        end
    end

    // Lanes in use form one run from lane 0; lanes of absent channels stay off
    assign en_mask = (9'h001 << jlp_lanes(mode_r, variant_r)) - 9'h001;

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    assign bi.push_valid = pend_r;
    assign bi.push_data = {jlp_octets(mode_r),
                           en_mask[LANES-1:0],
                           lanes_flat};
    assign bi.pop_ready = out_ready;

    // Two entries let the receiver stall a frame while the next one is gathered
    jlp_frame_buf u_buf (
        .clock(clock),
        .rst(rst),
        .bus(bi.store)
    );

    assign out_valid = bi.pop_valid;
    assign out_lanes = bi.pop_data[FRAME_W-1:0];
    assign out_lane_en = bi.pop_data[FRAME_W +: LANES];
    assign out_octets = bi.pop_data[BUF_W-1 -: 3];

endmodule

// ===== tb/jlp_packer_props.sv
// Port checker for the lane sample packer.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/10ps
module jlp_packer_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] link_mode_select,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [jlp_pkg::FRAME_W-1:0] out_lanes,
    input wire logic [jlp_pkg::LANES-1:0] out_lane_en,
    input wire logic [2:0] out_octets
);
    import jlp_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic fill_ok, pad_ok, t10_ok, t12_ok;
    always_comb begin
        fill_ok = 1'b1;
        pad_ok = 1'b1;
        t10_ok = 1'b1;
        t12_ok = 1'b1;
        for (int l = 0; l < LANES; l++) begin
            if (!out_lane_en[l] && out_lanes[l*LANE_W+:LANE_W] != '0) fill_ok = 1'b0;
            if ((out_lanes[l*LANE_W+:LANE_W] & (40'hff_ffff_ffff >> (8 * out_octets))) != '0) pad_ok = 1'b0;
            if ((out_lanes[l*LANE_W+:LANE_W] & 40'h00_4010_0401) != '0) t10_ok = 1'b0;
            if ((out_lanes[l*LANE_W+:LANE_W] & 40'h00_7007_0000) != '0) t12_ok = 1'b0;
        end
    end
    // After a low in_ready the packer stands at a frame start, so a mode 7 take ends its frame
    sequence s_take7;
        !$past(in_ready) && in_valid && in_ready && link_mode_select == 4'h7;
    endsequence
    sequence s_appear;
        !in_ready ##1 out_valid;
    endsequence
    a_octet_count: assert property (out_valid |-> out_octets inside {3'h1, 3'h2, 3'h3, 3'h5})
        else $error("bad octet count");
    a_lane_contig: assert property (out_valid |-> out_lane_en != '0 &&
        (out_lane_en & (out_lane_en + 8'h01)) == '0)
        else $error("lane enables not contiguous");
    a_unused_zero: assert property (out_valid |-> fill_ok)
        else $error("unused lane not zero");
    a_pad_zero: assert property (out_valid |-> pad_ok)
        else $error("octet beyond frame not zero");
    a_tail_one: assert property (out_valid && out_octets == 3'h5 |-> t10_ok)
        else $error("10-bit slot tail not zero");
    a_tail_three: assert property (out_valid && out_octets == 3'h3 |-> t12_ok)
        else $error("12-bit slot tail not zero");
    a_frame_gap: assert property (s_take7 |=> !in_ready)
        else $error("no gap after frame");
    a_frame_latency: assert property (s_take7 ##0 !out_valid |=> s_appear)
        else $error("frame late");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
        $stable(out_lanes) && $stable(out_lane_en) && $stable(out_octets))
        else $error("frame changed while stalled");
endmodule
bind jlp_packer jlp_packer_props jlp_packer_props_i (.clock, .rst, .link_mode_select, .in_valid, .in_ready,
    .out_valid, .out_ready, .out_lanes, .out_lane_en, .out_octets);

// ===== tb/jlp_rx_model.sv
// Link receiver model: accepts frames, queues them in arrival order.
// Assumes stall is driven by the bench; out_ready moves only after a clock edge.
`timescale 1ns/10ps
module jlp_rx_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic stall,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [jlp_pkg::FRAME_W-1:0] out_lanes,
    input wire logic [jlp_pkg::LANES-1:0] out_lane_en,
    input wire logic [2:0] out_octets
);
    import jlp_pkg::*;
    logic [FRAME_W+10:0] q[$];
    // Plain always: the bench pops this queue as well
    always @(posedge clock) begin
        out_ready <= !rst && !stall;
        if (!rst && out_valid && out_ready) begin
            q.push_back({out_octets, out_lane_en, out_lanes});
        end
    end
endmodule

// ===== tb/tb_jlp_lane_sample_packer.sv
// Self-checking bench for jlp_packer against the receiver model.
// Assumes the package, design files and jlp_rx_model are compiled first.
`timescale 1ns/10ps
module tb_jlp_lane_sample_packer;
    import jlp_pkg::*;
    typedef logic [FRAME_W+10:0] jlp_word_t;
    logic clock, rst, in_valid, in_ready, out_valid, out_ready, stall;
    logic [3:0] link_mode_select;
    logic [1:0] part_variant;
    logic [CHANS*SW-1:0] in_samp;
    logic [FRAME_W-1:0] out_lanes;
    logic [LANES-1:0] out_lane_en;
    logic [2:0] out_octets;
    int fail_count, n_tests;
    jlp_packer jlp_packer_i (.clock, .rst, .link_mode_select, .part_variant, .in_valid, .in_ready, .in_samp,
        .out_valid, .out_ready, .out_lanes, .out_lane_en, .out_octets);
    jlp_rx_model jlp_rx_model_i (.clock, .rst, .stall, .out_valid, .out_ready, .out_lanes, .out_lane_en, .out_octets);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    function automatic logic [8:0] smp(int c, int n, int f);
        return 9'((c * 8 + n) * 37 + f * 101 + 3);
    endfunction
    function automatic int spf_of(int m);
        return (m == 3) ? 4 : (m == 10) ? 8 : (m == 6 || m == 8 || m == 9) ? 2 : 1;
    endfunction
    // Slots of the channels present on part v laid end to end, MSB first, cut into lanes of lw bits; the rest stays zero
    function automatic logic [FRAME_W+10:0] expect_frame(int m, int v, int f);
        logic [FRAME_W-1:0] fr;
        logic [11:0] slot;
        int lw, w, k, n;
        fr = '0;
        k = 0;
        lw = (m == 3 || m == 10) ? 40 : (m == 8) ? 24 : (m == 7 || m == 9) ? 8 : 16;
        w = (m == 3 || m == 10) ? 10 : (m == 5 || m == 7 || m == 9) ? 8 : 12;
        for (int c = 0; c < ((v == 0) ? 4 : 3 - v); c++) begin
            for (int i = 0; i < spf_of(m); i++) begin
                n = (m == 10) ? ((i < 4) ? 2 * i : 2 * i - 7) : i;
                slot = (m == 5 && c == 1 && v != 1) ? 12'h000 : {smp(c, n, f), 3'h0};
                for (int b = 0; b < w; b++) begin
                    fr[(k / lw) * LANE_W + LANE_W - 1 - k % lw] = slot[11 - b];
                    k++;
                end
            end
        end
        return {3'(lw / 8), 8'((1 << ((k + lw - 1) / lw)) - 1), fr};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(string name, logic [FRAME_W+10:0] seen, logic [FRAME_W+10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic timed_out(string name);
        fail_count++;
        $display("unexpected timeout on %s", name);
        test_done();
    endtask
    task automatic send_frame(int m, int v, int f);
        int k;
        @(negedge clock);
        link_mode_select = 4'(m);
        part_variant = 2'(v);
        for (int n = 0; n < spf_of(m); n++) begin
            for (int c = 0; c < CHANS; c++) begin
                in_samp[c*SW+:SW] = smp(c, n, f);
            end
            in_valid = 1'b1;
            #1;
            for (k = 0; k < 50 && in_ready !== 1'b1; k++) begin
                @(negedge clock);
            end
            if (in_ready !== 1'b1) timed_out("in_ready");
            @(negedge clock);
        end
        in_valid = 1'b0;
    endtask
    task automatic get_frame(string name, logic [FRAME_W+10:0] exp);
        int k;
        for (k = 0; k < 100 && jlp_rx_model_i.q.size() == 0; k++) begin
            @(negedge clock);
        end
        if (jlp_rx_model_i.q.size() == 0) timed_out(name);
        check(name, jlp_rx_model_i.q.pop_front(), exp);
    endtask
    task automatic t_modes();
        jlp_word_t e;
        for (int m = 3; m <= 10; m++) begin
            for (int v = 0; v < 3; v++) begin
                e = expect_frame(m, v, 0);
                send_frame(m, v, 0);
                get_frame("frame", e);
                check("extra frame", jlp_word_t'(jlp_rx_model_i.q.size()), '0);
            end
        end
    endtask
    // Receiver stalls: two frames buffered, a third held pending, input refused
    task automatic t_stall();
        stall = 1'b1;
        for (int f = 1; f <= 3; f++) send_frame(7, 0, f);
        repeat (10) @(negedge clock);
        check("in_ready full", jlp_word_t'(in_ready), jlp_word_t'(1'b0));
        stall = 1'b0;
        for (int f = 1; f <= 3; f++) get_frame("queued", expect_frame(7, 0, f));
    endtask
    initial begin
        rst = 1'b1;
        in_valid = 1'b0;
        stall = 1'b0;
        link_mode_select = 4'h3;
        part_variant = 2'h0;
        in_samp = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        t_modes();
        t_stall();
        test_done();
    end
endmodule
